// [dv/iprc_core_model.sv]
// behavioural core that accepts offers and issues handler returns
`timescale 1ns/1ps
`default_nettype none
module iprc_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire iprc_pkg::iprc_req_t core_req,
    input wire logic ack_en,
    input wire logic [1:0] ack_dly,
    input wire logic ret_req,
    output logic irq_ack,
    output logic trap_ack,
    output logic return_from_interrupt
);
    import iprc_pkg::*;
    logic [1:0] wait_cnt;
    wire logic offer = core_req.irq_valid || core_req.trap_valid;
    // a slow core lets an offer stand; traps are taken before irqs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 2'h0;
            irq_ack <= 1'b0;
            trap_ack <= 1'b0;
            return_from_interrupt <= 1'b0;
        end else begin
            irq_ack <= 1'b0;
            trap_ack <= 1'b0;
            return_from_interrupt <= ret_req;
            if (ack_en && offer && !irq_ack && !trap_ack) begin
                wait_cnt <= wait_cnt + 2'h1;
                if (wait_cnt >= ack_dly) begin
                    wait_cnt <= 2'h0;
                    trap_ack <= core_req.trap_valid;
                    irq_ack <= !core_req.trap_valid;
                end
            end else begin
                wait_cnt <= 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// [dv/iprc_top_asserts.sv]
// assertions on the ports of the interrupt priority control top
`timescale 1ns/1ps
`default_nettype none
`include "iprc_defines.svh"
module iprc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq_ack,
    input wire logic trap_ack,
    input wire logic return_from_interrupt,
    input wire logic disable_start,
    input wire logic [`IPRC_TIMED_INTERRUPT_DISABLE_W-1:0] disable_cycles,
    input wire iprc_pkg::iprc_req_t core_req,
    input wire logic [`IPRC_PRIO_W-1:0] cpu_level
);
    import iprc_pkg::*;
    localparam logic [31:0] impl_mask [8] = '{32'h0770, 32'h0770, 32'h0700, 32'h7770,
        32'h800F, 32'h00FF, 32'h00FF, 32'h00E0};
    logic [14:0] dis_age;
    logic [13:0] dis_len;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // age since the last timed disable start; saturates so it never wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dis_age <= 15'h0;
            dis_len <= 14'h0;
        end else if (disable_start) begin
            dis_age <= 15'h0;
            dis_len <= disable_cycles;
        end else if (dis_age != 15'h4000) begin
            dis_age <= dis_age + 15'h1;
        end
    end
    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one access cycle");
    a_apb_slverr: assert property (psel && !penable |=> pslverr == (|paddr[31:5] || |paddr[1:0]))
        else $error("pslverr wrong for address");
    a_reserved_zero: assert property (psel && penable && pready && !pwrite
        |-> (prdata & ~(paddr[31:5] != 27'h0 ? 32'h0 : impl_mask[paddr[4:2]])) == 32'h0)
        else $error("unimplemented bits read nonzero");
    a_level_nonzero: assert property (core_req.irq_valid |-> core_req.irq_level != 3'h0)
        else $error("disabled level offered");
    a_above_level: assert property (core_req.irq_valid |-> core_req.irq_level > $past(cpu_level))
        else $error("offer not above cpu level");
    a_ack_level: assert property (core_req.irq_valid && irq_ack && !core_req.trap_valid
        |=> !core_req.irq_valid && cpu_level == $past(core_req.irq_level))
        else $error("ack did not raise cpu level");
    a_disable_mask: assert property (core_req.irq_valid && dis_age >= 15'h3
        && dis_age + 15'h4 <= dis_len |-> core_req.irq_level == 3'h7)
        else $error("low level offered in timed disable");
    a_level_cause: assert property (cpu_level != $past(cpu_level)
        |-> $past(irq_ack || trap_ack || return_from_interrupt
        || (psel && penable && pwrite && paddr == 32'h1C)))
        else $error("cpu level changed without cause");
endmodule
bind iprc_top iprc_checker u_iprc_checker (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .irq_ack, .trap_ack, .return_from_interrupt,
    .disable_start, .disable_cycles, .core_req, .cpu_level);
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the interrupt priority control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import iprc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, wd;
    logic pready, pslverr, err, irq_ack, trap_ack, return_from_interrupt;
    logic [7:0] src_event = 8'h0, pend;
    logic [3:0] trap_event = 4'h0, want;
    logic disable_start = 1'b0, ack_en = 1'b0, ret_req = 1'b0;
    logic [13:0] disable_cycles = 14'h0;
    logic [1:0] ack_dly = 2'h0;
    logic [2:0] cpu_level, lv [8];
    iprc_req_t core_req;
    integer seed = 64206, bad_count = 0, tests_run = 0;
    logic [31:0] msk [4] = '{32'h0770, 32'h0770, 32'h0700, 32'h7770};
    logic [31:0] rst [4] = '{32'h0440, 32'h0440, 32'h0400, 32'h4440};
    iprc_top u_iprc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .src_event, .trap_event, .irq_ack, .trap_ack,
        .return_from_interrupt, .disable_start, .disable_cycles, .core_req, .cpu_level);
    iprc_core_model u_iprc_core_model (.pclk, .presetn, .core_req, .ack_en, .ack_dly,
        .ret_req, .irq_ack, .trap_ack, .return_from_interrupt);
    always #12.5 pclk = ~pclk;
    task automatic end_of_test;
        $display("tests_run %0d bad_count %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        integer n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            check("pready", pready, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // fields placed as the priority registers lay them out
    task automatic set_prio;
        apb(1'b1, 32'h0, {21'h0, lv[0], 1'h0, lv[1], 4'h0});
        apb(1'b1, 32'h4, {21'h0, lv[2], 1'h0, lv[3], 4'h0});
        apb(1'b1, 32'h8, {21'h0, lv[4], 8'h0});
        apb(1'b1, 32'hC, {17'h0, lv[5], 1'h0, lv[6], 1'h0, lv[7], 4'h0});
    endtask
    task automatic pulse_src(input logic [7:0] p);
        @(posedge pclk);
        src_event <= p;
        @(posedge pclk);
        src_event <= 8'h0;
    endtask
    task automatic do_ret;
        @(posedge pclk);
        ret_req <= 1'b1;
        @(posedge pclk);
        ret_req <= 1'b0;
    endtask
    task automatic wait_lvl(input logic [2:0] l);
        for (int n = 0; n < 40 && cpu_level !== l; n++)
            @(posedge pclk);
    endtask
    task automatic wait_valid;
        for (int n = 0; n < 20 && core_req.irq_valid !== 1'b1 && core_req.trap_valid !== 1'b1; n++)
            @(posedge pclk);
    endtask
    // highest level wins, lower index on a tie, level zero never
    function automatic logic [3:0] best(input logic [7:0] p);
        logic [3:0] r;
        logic [2:0] top;
        r = 4'h0;
        top = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (p[i] && lv[i] > top) begin
                top = lv[i];
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction
    initial begin
        #500000;
        bad_count = bad_count + 1;
        end_of_test;
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 32'(4 * i), 32'h0);
            check("prio reset", rd, rst[i]);
        end
        $display("test reset done");
        for (int k = 0; k < 12; k++) begin
            wd = k == 0 ? 32'hFFFFFFFF : $random(seed);
            apb(1'b1, 32'(4 * (k % 4)), wd);
            apb(1'b0, 32'(4 * (k % 4)), 32'h0);
            check("prio field", rd, wd & msk[k % 4]);
        end
        apb(1'b1, 32'h40, 32'hFFFFFFFF);
        apb(1'b0, 32'h40, 32'h0);
        check("unmapped read", {err, rd[30:0]}, 32'h80000000);
        $display("test fields done");
        for (int k = 0; k < 10; k++) begin
            for (int i = 0; i < 8; i++)
                lv[i] = k == 0 ? 3'h3 : 3'($random(seed));
            set_prio;
            apb(1'b1, 32'h14, 32'h0);
            apb(1'b1, 32'h18, 32'hFF);
            pend = k == 1 ? 8'hFF : 8'($random(seed));
            pulse_src(pend);
            repeat (4) @(posedge pclk);
            want = best(pend);
            check("offer", {core_req.irq_valid, want[3] ? core_req.irq_id : 3'h0}, want);
            if (want[3])
                check("offer level", core_req.irq_level, lv[want[2:0]]);
            apb(1'b1, 32'h18, 32'h0);
        end
        $display("test arbitration done");
        for (int i = 0; i < 8; i++)
            lv[i] = 3'h0;
        lv[4] = 3'h5;
        lv[5] = 3'h6;
        set_prio;
        apb(1'b1, 32'h14, 32'h0);
        apb(1'b1, 32'h18, 32'h30);
        ack_dly <= 2'($random(seed));
        ack_en <= 1'b1;
        pulse_src(8'h10);
        wait_lvl(3'h5);
        check("cpu level ack", cpu_level, 3'h5);
        pulse_src(8'h20);
        wait_lvl(3'h6);
        check("cpu level nested", cpu_level, 3'h6);
        apb(1'b1, 32'h14, 32'h10);
        do_ret;
        wait_lvl(3'h5);
        check("cpu level popped", cpu_level, 3'h5);
        do_ret;
        wait_lvl(3'h0);
        check("cpu level base", cpu_level, 3'h0);
        wait_lvl(3'h5);
        check("flag retaken", cpu_level, 3'h5);
        apb(1'b1, 32'h14, 32'h0);
        do_ret;
        $display("test return done");
        ack_en <= 1'b0;
        lv[4] = 3'h7;
        set_prio;
        apb(1'b1, 32'h1C, 32'hE0);
        pulse_src(8'h10);
        repeat (6) @(posedge pclk);
        check("masked at seven", {core_req.irq_valid, cpu_level}, 4'h7);
        @(posedge pclk);
        trap_event <= 4'h4;
        @(posedge pclk);
        trap_event <= 4'h0;
        wait_valid;
        check("trap offer", {core_req.trap_valid, core_req.trap_id}, 32'h6);
        ack_en <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b0, 32'h10, 32'h0);
        check("trap flag held", rd, 32'h4);
        apb(1'b1, 32'h10, 32'h0);
        apb(1'b0, 32'h10, 32'h0);
        check("trap flag clear", rd, 32'h0);
        do_ret;
        ack_en <= 1'b0;
        apb(1'b1, 32'h1C, 32'h0);
        wait_valid;
        check("unmasked", {core_req.irq_valid, core_req.irq_id}, 4'hC);
        apb(1'b1, 32'h14, 32'h0);
        $display("test masking done");
        lv[4] = 3'h6;
        lv[5] = 3'h7;
        set_prio;
        disable_cycles <= 14'h00C8;
        disable_start <= 1'b1;
        @(posedge pclk);
        disable_start <= 1'b0;
        pulse_src(8'h10);
        repeat (10) @(posedge pclk);
        check("timed mask", core_req.irq_valid, 1'b0);
        pulse_src(8'h20);
        wait_valid;
        check("level seven passes", {core_req.irq_valid, core_req.irq_id}, 4'hD);
        apb(1'b1, 32'h14, 32'h10);
        repeat (200) @(posedge pclk);
        wait_valid;
        check("after timed mask", {core_req.irq_valid, core_req.irq_id}, 4'hC);
        $display("test timed done");
        apb(1'b1, 32'h10, 32'h8000);
        ack_en <= 1'b1;
        wait_lvl(3'h6);
        pulse_src(8'h20);
        repeat (10) @(posedge pclk);
        check("no preempt", cpu_level, 3'h6);
        apb(1'b1, 32'h14, 32'h20);
        do_ret;
        wait_lvl(3'h7);
        check("served after return", cpu_level, 3'h7);
        apb(1'b1, 32'h14, 32'h0);
        do_ret;
        wait_lvl(3'h0);
        check("back to base", cpu_level, 3'h0);
        $display("test nesting done");
        end_of_test;
    end
endmodule
`default_nettype wire

// [logic/iprc_arbiter.sv]
// picks the highest-priority pending user source above a threshold
`timescale 1ns/1ps
`default_nettype none
`include "iprc_defines.svh"

module iprc_arbiter (
    input wire logic [`IPRC_N_SRC*`IPRC_PRIO_W-1:0] prio,
    input wire logic [`IPRC_N_SRC-1:0] pending,
    input wire logic [`IPRC_PRIO_W-1:0] threshold,
    output logic win_valid,
    output logic [2:0] win_id,
    output logic [`IPRC_PRIO_W-1:0] win_level
);
    logic [`IPRC_N_SRC-1:0] live;
    logic [`IPRC_PRIO_W-1:0] best_lvl [`IPRC_N_SRC:0];
    logic [2:0] best_id [`IPRC_N_SRC:0];

    assign best_lvl[0] = `IPRC_PRIO_OFF;
    assign best_id[0] = 3'h0;

    genvar i;
    generate
        for (i = 0; i < `IPRC_N_SRC; i = i + 1) begin : g_src
            wire [`IPRC_PRIO_W-1:0] lvl = prio[i*`IPRC_PRIO_W +: `IPRC_PRIO_W];
            // level 000 never wins, so a disabled source drops out here
            assign live[i] = pending[i] && (lvl > threshold) && (lvl != `IPRC_PRIO_OFF);
            // strictly greater: on a tie the lower index keeps the grant
            assign best_lvl[i+1] = (live[i] && lvl > best_lvl[i]) ? lvl : best_lvl[i];
            assign best_id[i+1] = (live[i] && lvl > best_lvl[i]) ? 3'(i) : best_id[i];
        end
    endgenerate

    assign win_valid = |live;
    assign win_id = best_id[`IPRC_N_SRC];
    assign win_level = best_lvl[`IPRC_N_SRC];
endmodule
`default_nettype wire

// [logic/iprc_defines.svh]
// constants for the interrupt priority control block
`ifndef IPRC_DEFINES_SVH
`define IPRC_DEFINES_SVH

`define IPRC_ADDR_W 5
`define IPRC_OFF_PRIO_I2C2 5'h00
`define IPRC_OFF_PRIO_EXT 5'h04
`define IPRC_OFF_PRIO_CAL 5'h08
`define IPRC_OFF_PRIO_ERR 5'h0C
`define IPRC_OFF_CTRL1 5'h10
`define IPRC_OFF_FLAGS 5'h14
`define IPRC_OFF_ENABLES 5'h18
`define IPRC_OFF_STATUS 5'h1C

`define IPRC_PRIO_W 3
`define IPRC_PRIO_RESET 3'h4
`define IPRC_PRIO_OFF 3'h0
`define IPRC_PRIO_TOP 3'h7
`define IPRC_TIMED_INTERRUPT_DISABLE_CEIL 3'h6

`define IPRC_HI_LSB 8
`define IPRC_LO_LSB 4
`define IPRC_TOP_LSB 12

`define IPRC_MASK_I2C2 16'h0770
`define IPRC_MASK_EXT 16'h0770
`define IPRC_MASK_CAL 16'h0700
`define IPRC_MASK_ERR 16'h7770
`define IPRC_RST_I2C2 16'h0440
`define IPRC_RST_EXT 16'h0440
`define IPRC_RST_CAL 16'h0400
`define IPRC_RST_ERR 16'h4440

`define IPRC_NEST_BIT 15
`define IPRC_LEVEL_LSB 5
`define IPRC_N_SRC 8
`define IPRC_N_TRAP 4
`define IPRC_STACK_D 8
`define IPRC_DEPTH_W 4
`define IPRC_TIMED_INTERRUPT_DISABLE_W 14

`endif

// [logic/iprc_disable_timer.sv]
// countdown for the timed interrupt disable
`timescale 1ns/1ps
`default_nettype none
`include "iprc_defines.svh"

module iprc_disable_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [`IPRC_TIMED_INTERRUPT_DISABLE_W-1:0] cycles,
    output logic active
);
    logic [`IPRC_TIMED_INTERRUPT_DISABLE_W-1:0] count_reg;
    logic [`IPRC_TIMED_INTERRUPT_DISABLE_W-1:0] count_next;

    // a new start reloads, so the later window always wins
    assign count_next = start ? cycles :
        (count_reg != '0) ? count_reg - `IPRC_TIMED_INTERRUPT_DISABLE_W'(1) : count_reg;
    assign active = (count_reg != '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule
`default_nettype wire

// [logic/iprc_pkg.sv]
// types shared by the interrupt priority control block
package iprc_pkg;
    typedef struct packed {
        logic irq_valid;
        logic [2:0] irq_id;
        logic [2:0] irq_level;
        logic trap_valid;
        logic [1:0] trap_id;
    } iprc_req_t;

    typedef enum logic [1:0] {
        IPRC_IDLE = 2'h0,
        IPRC_OFFER_IRQ = 2'h1,
        IPRC_OFFER_TRAP = 2'h2
    } iprc_state_t;
endpackage

// [logic/iprc_top.sv]
// interrupt priority control: priority registers, masking and core handshake
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "iprc_defines.svh"

module iprc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`IPRC_N_SRC-1:0] src_event,
    input wire logic [`IPRC_N_TRAP-1:0] trap_event,
    input wire logic irq_ack,
    input wire logic trap_ack,
    input wire logic return_from_interrupt,
    input wire logic disable_start,
    input wire logic [`IPRC_TIMED_INTERRUPT_DISABLE_W-1:0] disable_cycles,
    output iprc_pkg::iprc_req_t core_req,
    output logic [`IPRC_PRIO_W-1:0] cpu_level
);
    import iprc_pkg::*;

    logic [15:0] prio_i2c2_reg;
    logic [15:0] prio_ext_reg;
    logic [15:0] prio_cal_reg;
    logic [15:0] prio_err_reg;
    logic nest_dis_reg;
    logic [`IPRC_N_TRAP-1:0] trap_flag_reg;
    logic [`IPRC_N_SRC-1:0] flag_reg;
    logic [`IPRC_N_SRC-1:0] enable_reg;
    logic [`IPRC_PRIO_W-1:0] level_reg;
    logic [`IPRC_PRIO_W-1:0] level_next;
    logic [`IPRC_PRIO_W-1:0] stack_reg [`IPRC_STACK_D];
    logic [`IPRC_DEPTH_W-1:0] depth_reg;
    logic [`IPRC_DEPTH_W-1:0] depth_next;
    logic trap_busy_reg;
    logic trap_busy_next;
    iprc_state_t state_reg;
    iprc_state_t state_next;
    iprc_req_t req_reg;
    iprc_req_t req_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pslverr_reg;

    // apb decode: the answer is prepared in the setup cycle, so the
    // access phase always completes with no wait states
    wire setup = psel && !penable;
    wire access = psel && penable && pready_reg;
    wire wr = access && pwrite;
    wire [`IPRC_ADDR_W-1:0] addr = paddr[`IPRC_ADDR_W-1:0];
    wire hi_zero = (paddr[31:`IPRC_ADDR_W] == '0);
    wire hit_i2c2 = hi_zero && addr == `IPRC_OFF_PRIO_I2C2;
    wire hit_ext = hi_zero && addr == `IPRC_OFF_PRIO_EXT;
    wire hit_cal = hi_zero && addr == `IPRC_OFF_PRIO_CAL;
    wire hit_err = hi_zero && addr == `IPRC_OFF_PRIO_ERR;
    wire hit_ctrl = hi_zero && addr == `IPRC_OFF_CTRL1;
    wire hit_flags = hi_zero && addr == `IPRC_OFF_FLAGS;
    wire hit_en = hi_zero && addr == `IPRC_OFF_ENABLES;
    wire hit_stat = hi_zero && addr == `IPRC_OFF_STATUS;
    wire mapped = hit_i2c2 || hit_ext || hit_cal || hit_err ||
        hit_ctrl || hit_flags || hit_en || hit_stat;

    // writes to priority registers keep only implemented fields
    wire [15:0] i2c2_next = (wr && hit_i2c2) ? pwdata[15:0] & `IPRC_MASK_I2C2 : prio_i2c2_reg;
    wire [15:0] ext_next = (wr && hit_ext) ? pwdata[15:0] & `IPRC_MASK_EXT : prio_ext_reg;
    wire [15:0] cal_next = (wr && hit_cal) ? pwdata[15:0] & `IPRC_MASK_CAL : prio_cal_reg;
    wire [15:0] err_next = (wr && hit_err) ? pwdata[15:0] & `IPRC_MASK_ERR : prio_err_reg;

    // flags: a hardware event in the same cycle as a software clear wins
    wire [`IPRC_N_SRC-1:0] flag_next =
        ((wr && hit_flags) ? pwdata[`IPRC_N_SRC-1:0] : flag_reg) | src_event;
    wire [`IPRC_N_SRC-1:0] enable_next =
        (wr && hit_en) ? pwdata[`IPRC_N_SRC-1:0] : enable_reg;
    // trap flags can only be cleared by software, never set by it
    wire [`IPRC_N_TRAP-1:0] trap_next =
        ((wr && hit_ctrl) ? (trap_flag_reg & pwdata[`IPRC_N_TRAP-1:0]) : trap_flag_reg)
        | trap_event;
    wire nest_next = (wr && hit_ctrl) ? pwdata[`IPRC_NEST_BIT] : nest_dis_reg;

    // source order: i2c master, i2c slave, pin4, pin3, calendar,
    // checksum error, serial2 error, serial1 error
    wire [`IPRC_PRIO_W-1:0] i2c_master_event_prio = prio_i2c2_reg[`IPRC_HI_LSB +: `IPRC_PRIO_W];
    wire [`IPRC_PRIO_W-1:0] i2c_slave_event_prio = prio_i2c2_reg[`IPRC_LO_LSB +: `IPRC_PRIO_W];
    wire [`IPRC_PRIO_W-1:0] ext_pin4_prio = prio_ext_reg[`IPRC_HI_LSB +: `IPRC_PRIO_W];
    wire [`IPRC_PRIO_W-1:0] ext_pin3_prio = prio_ext_reg[`IPRC_LO_LSB +: `IPRC_PRIO_W];
    wire [`IPRC_PRIO_W-1:0] calendar_prio = prio_cal_reg[`IPRC_HI_LSB +: `IPRC_PRIO_W];
    wire [`IPRC_PRIO_W-1:0] checksum_error_prio = prio_err_reg[`IPRC_TOP_LSB +: `IPRC_PRIO_W];
    wire [`IPRC_PRIO_W-1:0] serial2_error_prio = prio_err_reg[`IPRC_HI_LSB +: `IPRC_PRIO_W];
    wire [`IPRC_PRIO_W-1:0] serial1_error_prio = prio_err_reg[`IPRC_LO_LSB +: `IPRC_PRIO_W];
    wire [`IPRC_N_SRC*`IPRC_PRIO_W-1:0] prio_all = {serial1_error_prio,
        serial2_error_prio, checksum_error_prio, calendar_prio, ext_pin3_prio,
        ext_pin4_prio, i2c_slave_event_prio, i2c_master_event_prio};

    // masking threshold
    logic disable_active;
    wire [`IPRC_PRIO_W-1:0] timed_interrupt_disable_floor = disable_active ? `IPRC_TIMED_INTERRUPT_DISABLE_CEIL : `IPRC_PRIO_OFF;
    wire [`IPRC_PRIO_W-1:0] threshold =
        (level_reg > timed_interrupt_disable_floor) ? level_reg : timed_interrupt_disable_floor;
    // with nesting disabled no user source is offered while a handler runs; traps still are during a user handler
    wire nest_block = nest_dis_reg && ((depth_reg != '0) || trap_busy_reg);
    wire [`IPRC_N_SRC-1:0] pending = nest_block ? '0 : (flag_reg & enable_reg);

    logic win_valid;
    logic [2:0] win_id;
    logic [`IPRC_PRIO_W-1:0] win_level;

    iprc_arbiter u_arbiter (
        .prio(prio_all),
        .pending(pending),
        .threshold(threshold),
        .win_valid(win_valid),
        .win_id(win_id),
        .win_level(win_level)
    );

    iprc_disable_timer u_disable_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(disable_start),
        .cycles(disable_cycles),
        .active(disable_active)
    );

    // traps are offered whatever the cpu level; lowest index first
    wire trap_pending = (trap_flag_reg != '0) && !trap_busy_reg;
    wire [1:0] trap_sel = trap_flag_reg[0] ? 2'h0 : trap_flag_reg[1] ? 2'h1 :
        trap_flag_reg[2] ? 2'h2 : 2'h3;

    wire take_irq = (state_reg == IPRC_OFFER_IRQ) && irq_ack;
    wire take_trap = (state_reg == IPRC_OFFER_TRAP) && trap_ack;
    // a return first closes a trap handler, then user handlers in turn
    wire pop = return_from_interrupt && !trap_busy_reg && (depth_reg != '0);
    wire push = take_irq && (depth_reg != `IPRC_DEPTH_W'(`IPRC_STACK_D));
    wire [`IPRC_DEPTH_W-1:0] top_idx = depth_reg - `IPRC_DEPTH_W'(1);
    wire sw_level_wr = wr && hit_stat;

    // cpu level: core events win over a software status write
    always_comb begin
        level_next = level_reg;
        if (sw_level_wr) begin
            level_next = pwdata[`IPRC_LEVEL_LSB +: `IPRC_PRIO_W];
        end
        if (take_irq) begin
            level_next = req_reg.irq_level;
        end else if (pop) begin
            level_next = stack_reg[top_idx[2:0]];
        end
    end

    assign depth_next = push ? depth_reg + `IPRC_DEPTH_W'(1) :
        pop ? top_idx : depth_reg;
    assign trap_busy_next = take_trap ? 1'b1 :
        (return_from_interrupt && trap_busy_reg) ? 1'b0 : trap_busy_reg;

    // offer state machine; a source still flagged after return simply
    // wins arbitration again once its level is unmasked
    always_comb begin
        state_next = state_reg;
        req_next = req_reg;
        case (state_reg)
            IPRC_IDLE: begin
                if (trap_pending) begin
                    state_next = IPRC_OFFER_TRAP;
                    req_next.trap_valid = 1'b1;
                    req_next.trap_id = trap_sel;
                end else if (win_valid) begin
                    state_next = IPRC_OFFER_IRQ;
                    req_next.irq_valid = 1'b1;
                    req_next.irq_id = win_id;
                    req_next.irq_level = win_level;
                end
            end
            IPRC_OFFER_IRQ: begin
                // withdraw when taken, masked, or preempted by a trap
                if (irq_ack || !win_valid || trap_pending) begin
                    state_next = IPRC_IDLE;
                    req_next.irq_valid = 1'b0;
                end else begin
                    req_next.irq_id = win_id;
                    req_next.irq_level = win_level;
                end
            end
            IPRC_OFFER_TRAP: begin
                if (trap_ack) begin
                    state_next = IPRC_IDLE;
                    req_next.trap_valid = 1'b0;
                end
            end
            default: begin
                state_next = IPRC_IDLE;
                req_next = '0;
            end
        endcase
    end

    // read mux
    always_comb begin
        prdata_next = '0;
        if (hit_i2c2) begin
            prdata_next[15:0] = prio_i2c2_reg;
        end else if (hit_ext) begin
            prdata_next[15:0] = prio_ext_reg;
        end else if (hit_cal) begin
            prdata_next[15:0] = prio_cal_reg;
        end else if (hit_err) begin
            prdata_next[15:0] = prio_err_reg;
        end else if (hit_ctrl) begin
            prdata_next[`IPRC_NEST_BIT] = nest_dis_reg;
            prdata_next[`IPRC_N_TRAP-1:0] = trap_flag_reg;
        end else if (hit_flags) begin
            prdata_next[`IPRC_N_SRC-1:0] = flag_reg;
        end else if (hit_en) begin
            prdata_next[`IPRC_N_SRC-1:0] = enable_reg;
        end else if (hit_stat) begin
            prdata_next[`IPRC_LEVEL_LSB +: `IPRC_PRIO_W] = level_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            if (setup) begin
                prdata_reg <= pwrite ? 32'h0000_0000 : prdata_next;
                pslverr_reg <= !mapped;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_i2c2_reg <= `IPRC_RST_I2C2;
            prio_ext_reg <= `IPRC_RST_EXT;
            prio_cal_reg <= `IPRC_RST_CAL;
            prio_err_reg <= `IPRC_RST_ERR;
        end else begin
            prio_i2c2_reg <= i2c2_next;
            prio_ext_reg <= ext_next;
            prio_cal_reg <= cal_next;
            prio_err_reg <= err_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nest_dis_reg <= 1'b0;
            trap_flag_reg <= '0;
            flag_reg <= '0;
            enable_reg <= '0;
        end else begin
            nest_dis_reg <= nest_next;
            trap_flag_reg <= trap_next;
            flag_reg <= flag_next;
            enable_reg <= enable_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_reg <= `IPRC_PRIO_OFF;
            depth_reg <= '0;
            trap_busy_reg <= 1'b0;
            state_reg <= IPRC_IDLE;
            req_reg <= '0;
        end else begin
            level_reg <= level_next;
            depth_reg <= depth_next;
            trap_busy_reg <= trap_busy_next;
            state_reg <= state_next;
            req_reg <= req_next;
        end
    end

    // saved levels; a push beyond the stack depth is dropped, a limit
    // the core never reaches since nesting needs rising levels
    genvar s;
    generate
        for (s = 0; s < `IPRC_STACK_D; s = s + 1) begin : g_stack
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stack_reg[s] <= `IPRC_PRIO_OFF;
                end else if (push && depth_reg[2:0] == 3'(s)) begin
                    stack_reg[s] <= level_reg;
                end
            end
        end
    endgenerate

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign core_req = req_reg;
    assign cpu_level = level_reg;
endmodule
`default_nettype wire
